// ### bench/sccl_ee_model.sv
// behavioural serial eeprom: command, address, dummy zero, sixteen data bits
`default_nettype none
module sccl_ee_model #(
    parameter int ABITS = 8
) (
    input  wire logic cs_i,
    input  wire logic sk_i,
    input  wire logic di_i,
    output var logic  do_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] mem [256];
    logic [15:0] sr;
    int          n;
    int          q [$];
    // one process owns the line; released line floats to the pull-up level
    initial begin
        n = 0;
        do_o = 1'b1;
        forever begin
            @(posedge sk_i or negedge cs_i);
            if (!cs_i) begin
                n = 0;
                do_o = 1'b1;
            end else begin
                if (n < 3 + ABITS) sr = {sr[14:0], di_i};
                n = n + 1;
                if (n == 3 + ABITS) begin
                    q.push_back(int'(sr) & ((1 << (3 + ABITS)) - 1));
                    do_o = 1'b0;
                end else if (n > 3 + ABITS && n <= 19 + ABITS) begin
                    do_o = mem[sr[ABITS-1:0]][19 + ABITS - n];
                end else if (n > 19 + ABITS) begin
                    do_o = 1'b1;
                end
            end
        end
    end
endmodule
`default_nettype wire

// ### bench/sccl_top_tb_top.sv
// self-checking bench: two loaders, one with a 256-word and one with a 64-word part
`default_nettype none
module sccl_top_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import sccl_pkg::*;
    logic        clk, rst_n, psel, pen, pwr, ok, er;
    logic [7:0]  pa;
    logic [31:0] pwd, rd, r1, r2;
    logic [15:0] img [7];
    int          n_errors, comparisons, seed, t;
    int          wa [7] = '{0, 1, 2, 10, 11, 12, 13};
    logic [15:0] top3 [5] = '{16'h6000, 16'h4000, 16'hC000, 16'h2000, 16'h8000};
    wire logic [1:0]  cs, sk, di, dout, prdy, perr, bd, dpi, dpa, stb, crh, s256, done;
    wire logic [31:0] prd [2];
    wire logic [47:0] sta [2];
    wire logic [2:0]  rev [2];
    wire logic [15:0] sid [2], svn [2];
    for (genvar g = 0; g < 2; g++) begin : u
        sccl_top dut (.CLK_I(clk), .RST_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(pen),
            .PWRITE_I(pwr), .PADDR_I(pa), .PWDATA_I(pwd), .PRDATA_O(prd[g]),
            .PREADY_O(prdy[g]), .PSLVERR_O(perr[g]), .EE_CS_O(cs[g]), .EE_SK_O(sk[g]),
            .EE_DI_O(di[g]), .EE_DO_I(dout[g]), .STATION_ADDRESS_O(sta[g]),
            .BOOT_ROM_DISABLE_O(bd[g]), .SILICON_STEP_LOW_BITS_O(rev[g]),
            .DEEP_SLEEP_INHIBIT_O(dpi[g]), .DEEP_SLEEP_ALLOW_O(dpa[g]),
            .IDLE_STANDBY_ALLOW_O(stb[g]), .CLOCK_REQUEST_HOLD_O(crh[g]),
            .SUBSYSTEM_ID_O(sid[g]), .SUBSYSTEM_VENDOR_O(svn[g]),
            .EE_SIZE_256_O(s256[g]), .LOAD_DONE_O(done[g]));
        sccl_ee_model #(.ABITS(g == 0 ? 8 : 6)) m (.cs_i(cs[g]), .sk_i(sk[g]),
            .di_i(di[g]), .do_o(dout[g]));
    end
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task automatic results();
        $display("comparisons %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [63:0] got, input logic [63:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %s expected %0h seen %0h", nm, exp, got);
        end
    endtask
    // one idle edge first, so a release and a new setup never share a time step
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        pa <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (prdy[0] !== 1'b1 && k < 50);
        if (k >= 50) begin
            n_errors++;
            results();
        end
        rd = prd[0];
        er = perr[0];
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    initial begin
        {psel, pen, pwr, pa, pwd, rst_n, n_errors, comparisons} = '0;
        seed = 32'h9d22a4df;
        for (int k = 0; k < 5; k++) begin
            foreach (img[i]) img[i] = 16'($random(seed));
            img[3] = (img[3] & 16'h0F42) | top3[k];
            foreach (img[i]) {u[0].m.mem[wa[i]], u[1].m.mem[wa[i]]} = {img[i], img[i]};
            u[0].m.q.delete();
            u[1].m.q.delete();
            ok = img[3][15:14] == 2'b01;
            rst_n <= 1'b0;
            repeat (5) @(posedge clk);
            rst_n <= 1'b1;
            t = 0;
            while (done !== 2'b11 && t < 30000) begin
                @(posedge clk);
                t++;
            end
            if (t >= 30000) begin
                n_errors++;
                results();
            end
            // settings apply one edge after done rises, so look between edges
            @(negedge clk);
            for (int g = 0; g < 2; g++) begin
                chk("size256", s256[g], g == 0);
                chk("station", sta[g], {img[2], img[1], img[0]});
                chk("boot_off", bd[g], ok & img[3][11]);
                chk("step", rev[g], (ok && img[3][13]) ? img[3][10:8] : 3'h0);
                chk("inhibit", dpi[g], ok & img[3][6]);
                chk("standby", stb[g], ok & img[3][1]);
                chk("clkreq", crh[g], !(ok & img[3][1]));
                chk("subsys", {sid[g], svn[g]}, {img[4], img[5]});
            end
            chk("frames", {u[0].m.q.size(), u[1].m.q.size()}, {32'd7, 32'd7});
            for (int i = 0; i < 7; i++) begin
                chk("hdr256", u[0].m.q[i], 'h600 | wa[i]);
                chk("hdr64", u[1].m.q[i], 'h180 | wa[i]);
            end
            $display("load run %0d done", k);
        end
        apb(1'b1, SCCL_R_CTRL, 32'h0000_0002);
        repeat (4) @(posedge clk);
        chk("sleep_d3", dpa[0], !(ok & img[3][6]));
        apb(1'b1, SCCL_R_CTRL, 32'h0000_0006);
        repeat (4) @(posedge clk);
        chk("sleep_pme", dpa[0], 1'b0);
        r1 = $random(seed);
        r2 = $random(seed);
        apb(1'b1, SCCL_R_SWLO, r1);
        apb(1'b1, SCCL_R_SWHI, r2);
        chk("station_kept", sta[0], {img[2], img[1], img[0]});
        apb(1'b1, SCCL_R_CTRL, 32'h0000_0001);
        repeat (4) @(posedge clk);
        chk("station_sw", sta[0], {r2[15:0], r1});
        apb(1'b0, SCCL_R_STAT, 32'h0000_0000);
        chk("status", {er, rd[1:0]}, 3'b011);
        apb(1'b0, 8'h20, 32'h0000_0000);
        chk("unmapped", {er, rd}, {1'b1, 32'h0000_0000});
        $display("register test done");
        results();
    end
endmodule
`default_nettype wire

// ### design/sccl_pkg.sv
// constants, state types and decode helpers of the serial eeprom config loader
`default_nettype none
package sccl_pkg;
    // ----------------------------------------------------------------
    // serial clock timing (eeprom is clocked no faster than 1 MHz)
    // ----------------------------------------------------------------
    localparam int SCCL_CLK_NS      = 40;
    localparam int SCCL_SK_HALF_NS  = 500;
    localparam int SCCL_SK_HALF_CYC = (SCCL_SK_HALF_NS + SCCL_CLK_NS - 1) / SCCL_CLK_NS;
    localparam logic [4:0] SCCL_SK_HALF_LAST = 5'(SCCL_SK_HALF_CYC - 1);
    // ----------------------------------------------------------------
    // serial frame layout
    // ----------------------------------------------------------------
    localparam logic [2:0] SCCL_CMD_READ    = 3'h6;
    localparam logic [4:0] SCCL_CMD_LEN     = 5'h03;
    localparam logic [4:0] SCCL_ABITS_SMALL = 5'h06;
    localparam logic [4:0] SCCL_ABITS_LARGE = 5'h08;
    localparam logic [4:0] SCCL_DBITS       = 5'h10;
    localparam logic [2:0] SCCL_NWORDS      = 3'h7;
    localparam logic [7:0] SCCL_W_CFG       = 8'h0A;
    // ----------------------------------------------------------------
    // configuration word fields and their values after reset
    // ----------------------------------------------------------------
    localparam int SCCL_MARK_LSB = 14;
    localparam int SCCL_GATE_LSB = 13;
    localparam int SCCL_BD_BIT   = 11;
    localparam int SCCL_REV_LSB  = 8;
    localparam int SCCL_DPD_BIT  = 6;
    localparam int SCCL_STB_BIT  = 1;
    localparam logic [1:0] SCCL_MARK_OK  = 2'h1;
    localparam logic [2:0] SCCL_REV_GATE = 3'h3;
    localparam logic SCCL_BD_RST  = 1'b0;
    localparam logic SCCL_DPD_RST = 1'b0;
    localparam logic SCCL_STB_RST = 1'b0;
    // ----------------------------------------------------------------
    // register byte offsets and control bits
    // ----------------------------------------------------------------
    localparam logic [7:0] SCCL_R_CTRL = 8'h00;
    localparam logic [7:0] SCCL_R_STAT = 8'h04;
    localparam logic [7:0] SCCL_R_SWLO = 8'h08;
    localparam logic [7:0] SCCL_R_SWHI = 8'h0C;
    localparam logic [7:0] SCCL_R_ADLO = 8'h10;
    localparam logic [7:0] SCCL_R_ADHI = 8'h14;
    localparam logic [7:0] SCCL_R_CFG  = 8'h18;
    localparam logic [7:0] SCCL_R_SUBS = 8'h1C;
    localparam int SCCL_CTRL_LOAD = 0;
    localparam int SCCL_CTRL_D3   = 1;
    localparam int SCCL_CTRL_PME  = 2;

    typedef enum logic [3:0] {
        ST_BOOT  = 4'b0001,
        ST_WAIT  = 4'b0010,
        ST_APPLY = 4'b0100,
        ST_RUN   = 4'b1000
    } sccl_top_e;

    typedef enum logic [4:0] {
        S_IDLE = 5'b00001,
        S_CMD  = 5'b00010,
        S_ADDR = 5'b00100,
        S_DATA = 5'b01000,
        S_GAP  = 5'b10000
    } sccl_wire_e;

    function automatic logic [7:0] sccl_word_addr(input logic [2:0] idx);
        case (idx)
            3'h0:    sccl_word_addr = 8'h00;
            3'h1:    sccl_word_addr = 8'h01;
            3'h2:    sccl_word_addr = 8'h02;
            3'h3:    sccl_word_addr = SCCL_W_CFG;
            3'h4:    sccl_word_addr = 8'h0B;
            3'h5:    sccl_word_addr = 8'h0C;
            default: sccl_word_addr = 8'h0D;
        endcase
    endfunction

    function automatic logic sccl_hit(input logic [7:0] a, input logic [7:0] off);
        sccl_hit = (a == off);
    endfunction
endpackage
`default_nettype wire

// ### design/sccl_top.sv
// serial eeprom configuration loader with apb register access
`default_nettype none
// What this block does
// - works with 64 or 256 word parts
// - every access opens with command bits
// - six or eight address bits by size
// - eeprom dummy zero ends address field
// - reads words 0,1,2,A,B,C,D after reset
// - eeprom address used until software load command
// - word A honoured only with mark 01
// - word A bit 11 disables expansion rom
// - bits 10:8 become low step bits if bit 13 set
// - bit 6 gates deep sleep in D3
// - bit 1 set allows idle standby
// - bit 1 clear keeps clock request
module sccl_top
    import sccl_pkg::*;
#(
    parameter logic [2:0] SILICON_STEP_RESET = 3'h0
) (
    input  wire logic        CLK_I,
    input  wire logic        RST_N_I,
    input  wire logic        PSEL_I,
    input  wire logic        PENABLE_I,
    input  wire logic        PWRITE_I,
    input  wire logic [7:0]  PADDR_I,
    input  wire logic [31:0] PWDATA_I,
    output logic      [31:0] PRDATA_O,
    output logic             PREADY_O,
    output logic             PSLVERR_O,
    output logic             EE_CS_O,
    output logic             EE_SK_O,
    output logic             EE_DI_O,
    input  wire logic        EE_DO_I,
    output logic      [47:0] STATION_ADDRESS_O,
    output logic             BOOT_ROM_DISABLE_O,
    output logic      [2:0]  SILICON_STEP_LOW_BITS_O,
    output logic             DEEP_SLEEP_INHIBIT_O,
    output logic             DEEP_SLEEP_ALLOW_O,
    output logic             IDLE_STANDBY_ALLOW_O,
    output logic             CLOCK_REQUEST_HOLD_O,
    output logic      [15:0] SUBSYSTEM_ID_O,
    output logic      [15:0] SUBSYSTEM_VENDOR_O,
    output logic             EE_SIZE_256_O,
    output logic             LOAD_DONE_O
);
    // ----------------------------------------------------------------
    // reset release
    // ----------------------------------------------------------------
    logic [1:0] rst_sync_q;
    logic       rst_n;

    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end

    assign rst_n = rst_sync_q[1];

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        sccl_top_e   st;
        logic [2:0]  idx;
        logic        start;
        logic [47:0] ee_addr;
        logic [15:0] cfg;
        logic [15:0] sub_id;
        logic [15:0] sub_ven;
        logic [47:0] sw_addr;
        logic        use_sw;
        logic        d3;
        logic        pme;
        logic        done;
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
        logic [47:0] station;
        logic        bd;
        logic [2:0]  rev;
        logic        dsi;
        logic        dsa;
        logic        stb;
        logic        hold;
        logic        wide;
    } sccl_top_s;

    localparam sccl_top_s RST_Q = '{
        st: ST_BOOT, rev: SILICON_STEP_RESET, bd: SCCL_BD_RST, dsi: SCCL_DPD_RST,
        stb: SCCL_STB_RST, hold: 1'b1, wide: 1'b1, default: '0};

    sccl_top_s   q;
    sccl_top_s   n;
    logic        mark_ok;
    logic        cfg_ok;
    logic        access;
    logic        mapped;
    logic        load_cmd;
    logic [31:0] rdata;

    sccl_wire_if wif ();

    assign wif.start  = q.start;
    assign wif.addr   = sccl_word_addr(q.idx);
    assign wif.detect = (q.idx == 3'h0);

    sccl_wire u_wire (
        .clk_i   (CLK_I),
        .rst_ni  (rst_n),
        .wif     (wif),
        .ee_do_i (EE_DO_I),
        .ee_cs_o (EE_CS_O),
        .ee_sk_o (EE_SK_O),
        .ee_di_o (EE_DI_O)
    );

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        n       = q;
        n.start = 1'b0;
        mark_ok = (q.cfg[SCCL_MARK_LSB +: 2] == SCCL_MARK_OK);
        cfg_ok  = q.done && mark_ok;
        access  = PSEL_I && PENABLE_I;
        mapped  = (PADDR_I[1:0] == 2'h0) && (PADDR_I <= SCCL_R_SUBS);
        load_cmd = access && q.pready && PWRITE_I && sccl_hit(PADDR_I, SCCL_R_CTRL)
                   && PWDATA_I[SCCL_CTRL_LOAD];

        // boot read sequence, one word per engine request
        case (q.st)
            ST_BOOT: begin
                n.start = 1'b1;
                n.st    = ST_WAIT;
            end
            ST_WAIT: begin
                if (wif.done) begin
                    case (q.idx)
                        3'h0:    n.ee_addr[15:0]  = wif.data;
                        3'h1:    n.ee_addr[31:16] = wif.data;
                        3'h2:    n.ee_addr[47:32] = wif.data;
                        3'h3:    n.cfg            = wif.data;
                        3'h4:    n.sub_id         = wif.data;
                        3'h5:    n.sub_ven        = wif.data;
                        default: n.cfg            = q.cfg;
                    endcase
                    if (q.idx == 3'h0) begin
                        n.wide = wif.wide;
                    end
                    if (q.idx == SCCL_NWORDS - 3'h1) begin
                        n.st = ST_APPLY;
                    end else begin
                        n.idx   = q.idx + 3'h1;
                        n.start = 1'b1;
                    end
                end
            end
            ST_APPLY: begin
                n.done = 1'b1;
                n.st   = ST_RUN;
            end
            ST_RUN: begin
                n.st = ST_RUN;
            end
            default: begin
                n.st = ST_BOOT;
            end
        endcase

        // applied settings; without a good mark the defaults hold
        n.bd  = cfg_ok ? q.cfg[SCCL_BD_BIT] : SCCL_BD_RST;
        n.dsi = cfg_ok ? q.cfg[SCCL_DPD_BIT] : SCCL_DPD_RST;
        n.stb = cfg_ok ? q.cfg[SCCL_STB_BIT] : SCCL_STB_RST;
        n.hold = ~n.stb;
        n.dsa = q.done && q.d3 && !q.pme && !n.dsi;
        if (cfg_ok && q.cfg[SCCL_GATE_LSB +: 3] == SCCL_REV_GATE) begin
            n.rev = q.cfg[SCCL_REV_LSB +: 3];
        end else begin
            n.rev = SILICON_STEP_RESET;
        end
        if (!q.use_sw) begin
            n.station = q.ee_addr;
        end

        // register read data
        if (sccl_hit(PADDR_I, SCCL_R_CTRL)) begin
            rdata = {29'h0000_0000, q.pme, q.d3, 1'b0};
        end else if (sccl_hit(PADDR_I, SCCL_R_STAT)) begin
            rdata = {26'h000_0000, q.dsa, q.stb, q.use_sw, mark_ok, q.wide, q.done};
        end else if (sccl_hit(PADDR_I, SCCL_R_SWLO)) begin
            rdata = q.sw_addr[31:0];
        end else if (sccl_hit(PADDR_I, SCCL_R_SWHI)) begin
            rdata = {16'h0000, q.sw_addr[47:32]};
        end else if (sccl_hit(PADDR_I, SCCL_R_ADLO)) begin
            rdata = q.station[31:0];
        end else if (sccl_hit(PADDR_I, SCCL_R_ADHI)) begin
            rdata = {16'h0000, q.station[47:32]};
        end else if (sccl_hit(PADDR_I, SCCL_R_CFG)) begin
            rdata = {16'h0000, q.cfg};
        end else if (sccl_hit(PADDR_I, SCCL_R_SUBS)) begin
            rdata = {q.sub_ven, q.sub_id};
        end else begin
            rdata = 32'h0000_0000;
        end

        // one wait state, then the write lands on the ready edge
        if (access && !q.pready) begin
            n.pready  = 1'b1;
            n.pslverr = !mapped;
            n.prdata  = mapped ? rdata : 32'h0000_0000;
        end else if (access) begin
            n.pready  = 1'b0;
            n.pslverr = 1'b0;
            if (PWRITE_I && sccl_hit(PADDR_I, SCCL_R_CTRL)) begin
                n.d3  = PWDATA_I[SCCL_CTRL_D3];
                n.pme = PWDATA_I[SCCL_CTRL_PME];
            end else if (PWRITE_I && sccl_hit(PADDR_I, SCCL_R_SWLO)) begin
                n.sw_addr[31:0] = PWDATA_I;
            end else if (PWRITE_I && sccl_hit(PADDR_I, SCCL_R_SWHI)) begin
                n.sw_addr[47:32] = PWDATA_I[15:0];
            end
            if (load_cmd) begin
                n.use_sw  = 1'b1;
                n.station = q.sw_addr;
            end
        end else begin
            n.pready  = 1'b0;
            n.pslverr = 1'b0;
        end
    end

    always_ff @(posedge CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            q <= RST_Q;
        end else begin
            q <= n;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign PRDATA_O                = q.prdata;
    assign PREADY_O                = q.pready;
    assign PSLVERR_O               = q.pslverr;
    assign STATION_ADDRESS_O       = q.station;
    assign BOOT_ROM_DISABLE_O      = q.bd;
    assign SILICON_STEP_LOW_BITS_O = q.rev;
    assign DEEP_SLEEP_INHIBIT_O    = q.dsi;
    assign DEEP_SLEEP_ALLOW_O      = q.dsa;
    assign IDLE_STANDBY_ALLOW_O    = q.stb;
    assign CLOCK_REQUEST_HOLD_O    = q.hold;
    assign SUBSYSTEM_ID_O          = q.sub_id;
    assign SUBSYSTEM_VENDOR_O      = q.sub_ven;
    assign EE_SIZE_256_O           = q.wide;
    assign LOAD_DONE_O             = q.done;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!rst_n);

    sequence s_addr_cmd;
        load_cmd;
    endsequence

    sequence s_third_word_done;
        wif.done && q.idx == 3'h2 && q.st == ST_WAIT;
    endsequence

    a_first_word: assert property (
        wif.start && q.idx == 3'h0 |-> wif.detect && wif.addr == 8'h00)
        else $error("first boot read is not word zero with detection");
    a_word_order: assert property (
        s_third_word_done |=> wif.start && wif.addr == SCCL_W_CFG)
        else $error("config word not read after the address words");
    a_addr_swap: assert property (
        s_addr_cmd |=> q.use_sw && STATION_ADDRESS_O == $past(q.sw_addr) ##1 q.use_sw)
        else $error("load command did not switch the station address");
    a_mark_reject: assert property (
        q.done && !mark_ok |=> !BOOT_ROM_DISABLE_O && IDLE_STANDBY_ALLOW_O == SCCL_STB_RST)
        else $error("config word applied without a good mark");
    a_rom_off: assert property (
        q.done && mark_ok |=> BOOT_ROM_DISABLE_O == $past(q.cfg[SCCL_BD_BIT]))
        else $error("boot rom disable does not follow the config word");
    a_step_gate: assert property (
        q.done && q.cfg[15:13] != 3'h3 |=> SILICON_STEP_LOW_BITS_O == SILICON_STEP_RESET)
        else $error("step bits taken without the 011 gate");
    a_deep_sleep: assert property (
        q.done && q.d3 && !q.pme && mark_ok && !q.cfg[SCCL_DPD_BIT] |=> DEEP_SLEEP_ALLOW_O)
        else $error("deep sleep not allowed in D3 without wake");
    a_clock_hold: assert property (
        CLOCK_REQUEST_HOLD_O != IDLE_STANDBY_ALLOW_O)
        else $error("clock request hold not the inverse of standby allow");
endmodule
`default_nettype wire

// ### design/sccl_wire.sv
// serial engine: one eeprom word read per request, with size detection
`default_nettype none
module sccl_wire
    import sccl_pkg::*;
(
    input  wire logic clk_i,
    input  wire logic rst_ni,
    sccl_wire_if.eng  wif,
    input  wire logic ee_do_i,
    output logic      ee_cs_o,
    output logic      ee_sk_o,
    output logic      ee_di_o
);
    typedef struct packed {
        sccl_wire_e  st;
        logic [4:0]  cnt;
        logic        sk;
        logic        cs;
        logic        di;
        logic [4:0]  bitn;
        logic [15:0] sh;
        logic [15:0] data;
        logic        wide;
        logic        done;
        logic        d1;
        logic        d2;
    } sccl_wire_s;

    localparam sccl_wire_s RST_Q = '{st: S_IDLE, wide: 1'b1, d1: 1'b1, d2: 1'b1, default: '0};

    sccl_wire_s q;
    sccl_wire_s n;
    logic       half_end;
    logic       bit_end;
    logic       wide_now;

    always_comb begin
        n        = q;
        n.d1     = ee_do_i;
        n.d2     = q.d1;
        n.done   = 1'b0;
        half_end = (q.cnt == SCCL_SK_HALF_LAST);
        bit_end  = half_end && q.sk;
        wide_now = wif.detect || q.wide;
        if (q.st != S_IDLE) begin
            n.cnt = half_end ? 5'h00 : q.cnt + 5'h01;
        end
        if (half_end && q.st != S_GAP && q.st != S_IDLE) begin
            n.sk = ~q.sk;
        end
        case (q.st)
            S_IDLE: begin
                if (wif.start) begin
                    n.st   = S_CMD;
                    n.cs   = 1'b1;
                    n.cnt  = 5'h00;
                    n.sk   = 1'b0;
                    n.bitn = SCCL_CMD_LEN - 5'h01;
                    n.sh   = {SCCL_CMD_READ, 13'h0000};
                    n.di   = SCCL_CMD_READ[2];
                end
            end
            S_CMD: begin
                if (bit_end && q.bitn == 5'h00) begin
                    n.st   = S_ADDR;
                    n.sh   = wide_now ? {wif.addr, 8'h00} : {wif.addr[5:0], 10'h000};
                    n.bitn = (wide_now ? SCCL_ABITS_LARGE : SCCL_ABITS_SMALL) - 5'h01;
                    n.di   = n.sh[15];
                end else if (bit_end) begin
                    n.sh   = q.sh << 1;
                    n.bitn = q.bitn - 5'h01;
                    n.di   = q.sh[14];
                end
            end
            S_ADDR: begin
                // the dummy zero after six bits means the small part
                if (bit_end && wif.detect && !q.d2
                    && q.bitn == SCCL_ABITS_LARGE - SCCL_ABITS_SMALL) begin
                    n.wide = 1'b0;
                    n.st   = S_DATA;
                    n.bitn = SCCL_DBITS - 5'h01;
                    n.di   = 1'b0;
                end else if (bit_end && q.bitn == 5'h00) begin
                    if (wif.detect) begin
                        n.wide = 1'b1;
                    end
                    n.st   = S_DATA;
                    n.bitn = SCCL_DBITS - 5'h01;
                    n.di   = 1'b0;
                end else if (bit_end) begin
                    n.sh   = q.sh << 1;
                    n.bitn = q.bitn - 5'h01;
                    n.di   = q.sh[14];
                end
            end
            S_DATA: begin
                if (bit_end) begin
                    n.data = {q.data[14:0], q.d2};
                    n.bitn = q.bitn - 5'h01;
                    if (q.bitn == 5'h00) begin
                        n.st = S_GAP;
                        n.cs = 1'b0;
                    end
                end
            end
            S_GAP: begin
                if (half_end) begin
                    n.st   = S_IDLE;
                    n.done = 1'b1;
                end
            end
            default: begin
                n = RST_Q;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_ni) begin
        if (!rst_ni) begin
            q <= RST_Q;
        end else begin
            q <= n;
        end
    end

    assign ee_cs_o  = q.cs;
    assign ee_sk_o  = q.sk;
    assign ee_di_o  = q.di;
    assign wif.done = q.done;
    assign wif.data = q.data;
    assign wif.wide = q.wide;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_ni);

    sequence s_frame_open;
        $rose(q.cs);
    endsequence

    a_cmd_first: assert property (
        s_frame_open |-> q.st == S_CMD && q.di == SCCL_CMD_READ[2] && !q.sk)
        else $error("frame did not open with the command bits");
    a_size_small: assert property (
        q.st == S_ADDR && wif.detect && bit_end && q.bitn == 5'h02 && !q.d2
        |=> q.st == S_DATA && !q.wide && q.bitn == 5'h0F)
        else $error("dummy zero after six bits did not pick the small part");
    a_size_large: assert property (
        q.st == S_ADDR && wif.detect && bit_end && q.bitn == 5'h00 |=> q.wide)
        else $error("eight address bits did not pick the large part");
    a_addr_len: assert property (
        $rose(q.st == S_ADDR) |-> q.bitn == (q.wide || wif.detect ? 5'h07 : 5'h05))
        else $error("address field length wrong for the part size");
    a_sk_high: assert property (
        $rose(q.sk) |-> q.sk [*8])
        else $error("serial clock high phase too short");
endmodule
`default_nettype wire

// ### design/sccl_wire_if.sv
// request and answer signals between the loader and its serial engine
`default_nettype none
interface sccl_wire_if;
    logic        start;
    logic [7:0]  addr;
    logic        detect;
    logic        done;
    logic [15:0] data;
    logic        wide;
    modport ctrl (output start, output addr, output detect,
                  input done, input data, input wide);
    modport eng  (input start, input addr, input detect,
                  output done, output data, output wide);
endinterface
`default_nettype wire
